// >>> rtl/ogdpc_ctrl.sv
// Purpose: Configuration bytes and decoded group settings for a ten-output clock distributor.
// Assumes: A serial front end on clk_sys presents one byte access per cycle as a request.
// Notes: Steps for divide by 32 reads 31 since the field tops out at five bits; 32 is meant.
`default_nettype none
// How it works
// - Output 4 enable is bit 0 of byte 5, resets to 1, and 0 disables it.
// - Outputs 3 to 0 enables are bits 7 to 4 of byte 6, reset to 1, and 0 disables each.
// - The 4-bit ratio code decodes to 1,2,4,5,8,10,16,20,32,40,80 with 0000 as divide by one.
// - Phase lead applies to the upper group against the lower, whose lead is always zero.
// - Divide by 5 gives no phase adjustment whatever the phase field holds.
// - Divide by 1 gives no phase adjustment, and the phase field resets to zero.
// - Ratios 10, 20, 40, 80 ignore phase bit 0 and take k from bits upward of bit 1.
// - Ratio 80 uses phase bits 4 to 1 as k in sixteenths of a period.
// - Ratios 2, 4, 8, 16 take k from the low log2(ratio) phase bits.
// - Ratio 32 uses all five phase bits as k in thirty-seconds.
// - The upper phase field steers outputs 5 to 9; the lower field is stored but not decoded; both reset to 0.
// - Each group divider has an enable resetting to 1 that disables its five outputs.
// - The lower ratio field sits in bits 3 to 0 of its byte and resets to divide by one.
// - A chip enable resets to 1 and clearing it puts the device in a quiescent state.
module ogdpc_ctrl
  import ogdpc_pkg::*;
(
  input  wire logic                  clk_sys,
  input  wire logic                  rst,
  input  wire ogdpc_pkg::ogdpc_req_t req,
  output logic                 [7:0] rdata,
  output logic                       chip_enable,
  output logic                 [9:0] out_enable,
  output ogdpc_pkg::ogdpc_grp_t      upper_post_divider,
  output ogdpc_pkg::ogdpc_grp_t      lower_post_divider
);
  import ogdpc_pkg::*;

  logic [7:0] phase_up;
  logic [7:0] ratio_up;
  logic [7:0] phase_lo;
  logic [7:0] ratio_lo;
  logic [7:0] en_hi;
  logic [7:0] low_output_enables;
  logic [6:0] up_ratio;
  logic [4:0] up_lead;
  logic [4:0] up_steps;
  logic [6:0] lo_ratio;
  logic [4:0] lo_steps;
  logic [7:0] next_rdata;

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      phase_up           <= RST_PHASE_UP;
      ratio_up           <= RST_RATIO;
      phase_lo           <= RST_PHASE_LO;
      ratio_lo           <= RST_RATIO;
      en_hi              <= RST_OUT_EN_HI;
      low_output_enables <= RST_OUT_EN_LO;
    end
    else if (req.wr)
    begin
      if (req.addr == OFF_PHASE_UP)
        phase_up <= req.wdata;
      else if (req.addr == OFF_RATIO_UP)
        ratio_up <= req.wdata;
      else if (req.addr == OFF_PHASE_LO)
        phase_lo <= req.wdata;
      else if (req.addr == OFF_RATIO_LO)
        ratio_lo <= req.wdata;
      else if (req.addr == OFF_OUT_EN_HI)
        en_hi <= {req.wdata[7], 1'b1, req.wdata[5:0]};
      else if (req.addr == OFF_OUT_EN_LO)
        low_output_enables <= req.wdata;
    end
  end

  always_comb
  begin
    if (req.addr == OFF_PHASE_UP)
      next_rdata = phase_up;
    else if (req.addr == OFF_RATIO_UP)
      next_rdata = ratio_up;
    else if (req.addr == OFF_PHASE_LO)
      next_rdata = phase_lo;
    else if (req.addr == OFF_RATIO_LO)
      next_rdata = ratio_lo;
    else if (req.addr == OFF_OUT_EN_HI)
      next_rdata = en_hi;
    else if (req.addr == OFF_OUT_EN_LO)
      next_rdata = low_output_enables;
    else
      next_rdata = 8'h00;
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      rdata <= 8'h00;
    else
      rdata <= next_rdata;
  end

  ogdpc_ratio_dec u_dec_up (
    .sel   (ratio_up[3:0]),
    .phase (phase_up[4:0]),
    .ratio (up_ratio),
    .lead  (up_lead),
    .steps (up_steps)
  );

  ogdpc_ratio_dec u_dec_lo (
    .sel   (ratio_lo[3:0]),
    .phase (5'h00),
    .ratio (lo_ratio),
    .lead  (),
    .steps (lo_steps)
  );

  // Output enables gate on the chip enable and on each group's divider enable.
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      chip_enable        <= 1'b1;
      out_enable         <= 10'h3FF;
      upper_post_divider <= '{div_en: 1'b1, ratio: 7'd1, lead: 5'h00, steps: 5'h01};
      lower_post_divider <= '{div_en: 1'b1, ratio: 7'd1, lead: 5'h00, steps: 5'h01};
    end
    else
    begin
      chip_enable <= en_hi[POS_CHIP_EN];
      out_enable[9:5] <= en_hi[5:1] & {5{ratio_up[POS_DIV_EN] & en_hi[POS_CHIP_EN]}};
      out_enable[4] <= en_hi[POS_OUT4_EN] & ratio_lo[POS_DIV_EN]
                       & en_hi[POS_CHIP_EN];
      out_enable[3:0] <= low_output_enables[7:POS_OUT0_EN]
                         & {4{ratio_lo[POS_DIV_EN] & en_hi[POS_CHIP_EN]}};
      upper_post_divider.div_en <= ratio_up[POS_DIV_EN];
      upper_post_divider.ratio  <= up_ratio;
      upper_post_divider.lead   <= phase_up[POS_PHASE_EN] ? up_lead : 5'h00;
      upper_post_divider.steps  <= up_steps;
      lower_post_divider.div_en <= ratio_lo[POS_DIV_EN];
      lower_post_divider.ratio  <= lo_ratio;
      lower_post_divider.lead   <= 5'h00;
      lower_post_divider.steps  <= lo_steps;
    end
  end

  property p_lower_lead_zero;
    @(posedge clk_sys) disable iff (rst) lower_post_divider.lead == 5'h00;
  endproperty
  a_lower_lead_zero: assert property (p_lower_lead_zero) else $error("lower lead set");

  property p_div5_no_lead;
    @(posedge clk_sys) disable iff (rst)
      ($past(ratio_up[3:0]) == SEL_DIV5) |-> upper_post_divider.lead == 5'h00;
  endproperty
  a_div5_no_lead: assert property (p_div5_no_lead) else $error("lead at divide 5");

  property p_div1_no_lead;
    @(posedge clk_sys) disable iff (rst)
      ($past(ratio_up[3:0]) == SEL_DIV1) |-> upper_post_divider.ratio == 7'd1
        && upper_post_divider.lead == 5'h00;
  endproperty
  a_div1_no_lead: assert property (p_div1_no_lead) else $error("lead at divide 1");

  property p_div32_full;
    @(posedge clk_sys) disable iff (rst)
      ($past(ratio_up[3:0]) == SEL_DIV32 && $past(phase_up[POS_PHASE_EN]))
        |-> upper_post_divider.lead == $past(phase_up[4:0]);
  endproperty
  a_div32_full: assert property (p_div32_full) else $error("divide 32 lead wrong");

  property p_div80_bits;
    @(posedge clk_sys) disable iff (rst)
      ($past(ratio_up[3:0]) == SEL_DIV80 && $past(phase_up[POS_PHASE_EN]))
        |-> upper_post_divider.lead == {1'b0, $past(phase_up[4:1])};
  endproperty
  a_div80_bits: assert property (p_div80_bits) else $error("divide 80 lead wrong");

  property p_div10_bit1;
    @(posedge clk_sys) disable iff (rst)
      ($past(ratio_up[3:0]) == SEL_DIV10 && $past(phase_up[POS_PHASE_EN]))
        |-> upper_post_divider.lead == {4'h0, $past(phase_up[1])};
  endproperty
  a_div10_bit1: assert property (p_div10_bit1) else $error("divide 10 lead wrong");

  property p_div16_low;
    @(posedge clk_sys) disable iff (rst)
      ($past(ratio_up[3:0]) == SEL_DIV16 && $past(phase_up[POS_PHASE_EN]))
        |-> upper_post_divider.lead == {1'b0, $past(phase_up[3:0])};
  endproperty
  a_div16_low: assert property (p_div16_low) else $error("divide 16 lead wrong");

  property p_out4_write;
    @(posedge clk_sys) disable iff (rst)
      (req.wr && req.addr == OFF_OUT_EN_HI && !req.wdata[POS_OUT4_EN]) |=> ##1 !out_enable[4];
  endproperty
  a_out4_write: assert property (p_out4_write) else $error("output 4 still on");

  property p_low_en_write;
    @(posedge clk_sys) disable iff (rst)
      (req.wr && req.addr == OFF_OUT_EN_LO) |=> ##1
        (out_enable[3:0] & ~$past(low_output_enables[7:4])) == 4'h0;
  endproperty
  a_low_en_write: assert property (p_low_en_write) else $error("outputs 0-3 on while off");

  property p_chip_off;
    @(posedge clk_sys) disable iff (rst) !$past(en_hi[POS_CHIP_EN]) |-> out_enable == 10'h000
      && !chip_enable;
  endproperty
  a_chip_off: assert property (p_chip_off) else $error("outputs on while chip off");

  property p_lo_div_off;
    @(posedge clk_sys) disable iff (rst) !$past(ratio_lo[POS_DIV_EN]) |-> out_enable[4:0] == 5'h00;
  endproperty
  a_lo_div_off: assert property (p_lo_div_off) else $error("lower outputs on while off");

  property p_ph_off;
    @(posedge clk_sys) disable iff (rst)
      !$past(phase_up[POS_PHASE_EN]) |-> upper_post_divider.lead == 5'h00;
  endproperty
  a_ph_off: assert property (p_ph_off) else $error("lead while phase off");

  property p_div20_bits;
    @(posedge clk_sys) disable iff (rst)
      ($past(ratio_up[3:0]) == SEL_DIV20 && $past(phase_up[POS_PHASE_EN]))
        |-> upper_post_divider.lead == {3'h0, $past(phase_up[2:1])};
  endproperty
  a_div20_bits: assert property (p_div20_bits) else $error("divide 20 lead wrong");

  property p_lo_div5;
    @(posedge clk_sys) disable iff (rst)
      ($past(ratio_lo[3:0]) == SEL_DIV5) |-> lower_post_divider.ratio == 7'd5;
  endproperty
  a_lo_div5: assert property (p_lo_div5) else $error("lower ratio not 5");

  property p_div4_low;
    @(posedge clk_sys) disable iff (rst)
      ($past(ratio_up[3:0]) == SEL_DIV4 && $past(phase_up[POS_PHASE_EN]))
        |-> upper_post_divider.lead == {3'h0, $past(phase_up[1:0])};
  endproperty
  a_div4_low: assert property (p_div4_low) else $error("divide 4 lead wrong");
endmodule // ogdpc_ctrl
`default_nettype wire

// >>> rtl/ogdpc_pkg.sv
// Purpose: Shared constants and types for the output group divider and phase control block.
// Assumes: Byte-wide configuration registers reached by byte offset from the serial front end.
// Notes: Ratio codes above the last defined one are left to the host to avoid.
`default_nettype none
package ogdpc_pkg;
  localparam logic [2:0] OFF_PHASE_UP   = 3'h1;
  localparam logic [2:0] OFF_RATIO_UP   = 3'h2;
  localparam logic [2:0] OFF_PHASE_LO   = 3'h3;
  localparam logic [2:0] OFF_RATIO_LO   = 3'h4;
  localparam logic [2:0] OFF_OUT_EN_HI  = 3'h5;
  localparam logic [2:0] OFF_OUT_EN_LO  = 3'h6;
  localparam int POS_OUT4_EN   = 0;
  localparam int POS_OUT0_EN   = 4;
  localparam int POS_DIV_EN    = 5;
  localparam int POS_PHASE_EN  = 5;
  localparam int POS_CHIP_EN   = 7;
  localparam logic [7:0] RST_PHASE_UP  = 8'h20;
  localparam logic [7:0] RST_RATIO     = 8'h30;
  localparam logic [7:0] RST_PHASE_LO  = 8'h00;
  localparam logic [7:0] RST_OUT_EN_HI = 8'hFF;
  localparam logic [7:0] RST_OUT_EN_LO = 8'hF0;
  localparam logic [3:0] SEL_DIV1  = 4'h0;
  localparam logic [3:0] SEL_DIV2  = 4'h1;
  localparam logic [3:0] SEL_DIV4  = 4'h2;
  localparam logic [3:0] SEL_DIV5  = 4'h3;
  localparam logic [3:0] SEL_DIV8  = 4'h4;
  localparam logic [3:0] SEL_DIV10 = 4'h5;
  localparam logic [3:0] SEL_DIV16 = 4'h6;
  localparam logic [3:0] SEL_DIV20 = 4'h7;
  localparam logic [3:0] SEL_DIV32 = 4'h8;
  localparam logic [3:0] SEL_DIV40 = 4'h9;
  localparam logic [3:0] SEL_DIV80 = 4'hA;

  typedef struct packed {
    logic [2:0] addr;
    logic       wr;
    logic [7:0] wdata;
  } ogdpc_req_t;

  typedef struct packed {
    logic       div_en;
    logic [6:0] ratio;
    logic [4:0] lead;
    logic [4:0] steps;
  } ogdpc_grp_t;
endpackage
`default_nettype wire

// >>> rtl/ogdpc_ratio_dec.sv
// Purpose: Decodes one group ratio code and phase field into ratio, lead steps and step count.
// Assumes: Purely combinational; the caller registers the result.
// Notes: Undefined codes decode to divide by one with no lead.
`default_nettype none
module ogdpc_ratio_dec
  import ogdpc_pkg::*;
(
  input  wire logic [3:0] sel,
  input  wire logic [4:0] phase,
  output logic      [6:0] ratio,
  output logic      [4:0] lead,
  output logic      [4:0] steps
);
  import ogdpc_pkg::*;

  always_comb
  begin
    ratio = 7'd1;
    lead  = 5'h00;
    steps = 5'h01;
    case (sel)
      SEL_DIV1 :
        ratio = 7'd1;
      SEL_DIV2 :
      begin
        ratio = 7'd2;
        lead  = {4'h0, phase[0]};
        steps = 5'd2;
      end
      SEL_DIV4 :
      begin
        ratio = 7'd4;
        lead  = {3'h0, phase[1:0]};
        steps = 5'd4;
      end
      SEL_DIV5 :
        ratio = 7'd5;
      SEL_DIV8 :
      begin
        ratio = 7'd8;
        lead  = {2'h0, phase[2:0]};
        steps = 5'd8;
      end
      SEL_DIV10 :
      begin
        ratio = 7'd10;
        lead  = {4'h0, phase[1]};
        steps = 5'd2;
      end
      SEL_DIV16 :
      begin
        ratio = 7'd16;
        lead  = {1'b0, phase[3:0]};
        steps = 5'd16;
      end
      SEL_DIV20 :
      begin
        ratio = 7'd20;
        lead  = {3'h0, phase[2:1]};
        steps = 5'd4;
      end
      SEL_DIV32 :
      begin
        ratio = 7'd32;
        lead  = phase;
        steps = 5'd31;
      end
      SEL_DIV40 :
      begin
        ratio = 7'd40;
        lead  = {2'h0, phase[3:1]};
        steps = 5'd8;
      end
      SEL_DIV80 :
      begin
        ratio = 7'd80;
        lead  = {1'b0, phase[4:1]};
        steps = 5'd16;
      end
      default :
        ratio = 7'd1;
    endcase
  end
endmodule // ogdpc_ratio_dec
`default_nettype wire

// >>> bench/ogdpc_host.sv
// Purpose: Host model that issues byte reads and writes to the configuration block.
// Assumes: Requests change 1 ns after a rising edge of clk_sys and hold through the next one.
// Notes: Stands in for the serial front end; one byte per request, no word accesses.
`default_nettype none
module ogdpc_host
  import ogdpc_pkg::*;
(
  input  wire logic                  clk_sys,
  input  wire logic            [7:0] rdata,
  output var  ogdpc_pkg::ogdpc_req_t req
);
  timeunit 1ns;
  timeprecision 100ps;

  initial req = '0;

  // The strobe stays up for exactly one taking edge, so each call writes one byte.
  task automatic write_byte(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    #1;
    req = '{addr: a, wr: 1'b1, wdata: d};
    @(posedge clk_sys);
    #1;
    req.wr = 1'b0;
  endtask

  task automatic read_byte(input logic [2:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    #1;
    req = '{addr: a, wr: 1'b0, wdata: 8'h00};
    @(posedge clk_sys);
    #1;
    d = rdata;
  endtask
endmodule // ogdpc_host
`default_nettype wire

// >>> bench/tb.sv
// Purpose: Self-checking bench for the group divider and phase control block.
// Assumes: 40 MHz clock, reset held 20 cycles, decoded outputs settle two edges after a write.
// Notes: Expected leads and step counts are worked out here from the ratio and phase field.
`default_nettype none
module tb;
  import ogdpc_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;

  logic       clk_sys = 1'b0;
  logic       rst = 1'b1;
  ogdpc_req_t req;
  logic [7:0] rdata;
  logic       chip_enable;
  logic [9:0] out_enable;
  ogdpc_grp_t up;
  ogdpc_grp_t lo;
  int         n_fail = 0;
  int         cmp_count = 0;
  logic [7:0] rd;
  int         ratio_of [11] = '{1, 2, 4, 5, 8, 10, 16, 20, 32, 40, 80};
  logic [4:0] phs [4] = '{5'h00, 5'h1F, 5'h15, 5'h0A};
  logic [7:0] rst_b [8] = '{8'h00, 8'h20, 8'h30, 8'h00, 8'h30, 8'hFF, 8'hF0, 8'h00};
  logic [2:0] t_a [12] = '{3'h6, 3'h6, 3'h6, 3'h5, 3'h5, 3'h5, 3'h4, 3'h2, 3'h4, 3'h2,
                           3'h0, 3'h7};
  logic [7:0] t_d [12] = '{8'h00, 8'hA0, 8'hF0, 8'hBE, 8'h7F, 8'hFF, 8'h10, 8'h10, 8'h30,
                           8'h30, 8'h55, 8'h55};
  logic [7:0] t_r [12] = '{8'h00, 8'hA0, 8'hF0, 8'hFE, 8'h7F, 8'hFF, 8'h10, 8'h10, 8'h30,
                           8'h30, 8'h00, 8'h00};
  logic [9:0] t_o [12] = '{10'h3F0, 10'h3FA, 10'h3FF, 10'h3EF, 10'h000, 10'h3FF, 10'h3E0,
                           10'h000, 10'h01F, 10'h3FF, 10'h3FF, 10'h3FF};
  logic [1:0] t_v [12] = '{2'h3, 2'h3, 2'h3, 2'h3, 2'h3, 2'h3, 2'h2, 2'h0, 2'h1, 2'h3,
                           2'h3, 2'h3};

  always #12.5 clk_sys = ~clk_sys;

  ogdpc_host i_ogdpc_host (.clk_sys(clk_sys), .rdata(rdata), .req(req));

  ogdpc_ctrl i_ogdpc_ctrl (.clk_sys(clk_sys), .rst(rst), .req(req), .rdata(rdata),
    .chip_enable(chip_enable), .out_enable(out_enable), .upper_post_divider(up),
    .lower_post_divider(lo));

  task automatic check(input string what, input logic [9:0] seen, input logic [9:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic complete_run();
    $display("Compares %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic wr_settle(input logic [2:0] a, input logic [7:0] d);
    i_ogdpc_host.write_byte(a, d);
    repeat (2) @(posedge clk_sys);
    #1;
  endtask

  // Multiples of 5 step in ratio/5 and skip phase bit 0; divide by 32 reports 31 steps.
  function automatic logic [9:0] exp_val(input int ci, input int pi, input bit stp);
    int n;
    int k;
    int r;
    logic [4:0] ph;
    r = ratio_of[ci];
    ph = phs[pi];
    n = (r % 5 == 0) ? r / 5 : r;
    k = (r % 5 == 0) ? int'(ph >> 1) : int'(ph);
    k = (n == 1) ? 0 : k % n;
    if (stp)
      return (n == 32) ? 10'h01F : 10'(n);
    return 10'(k);
  endfunction

  initial
  begin
    #100us;
    n_fail++;
    complete_run();
  end

  initial
  begin
    repeat (20) @(posedge clk_sys);
    #1;
    rst = 1'b0;
    check("chip_enable", 10'(chip_enable), 10'h001);
    check("out_enable", out_enable, 10'h3FF);
    check("lower_ratio", 10'(lo.ratio), 10'h001);
    check("upper_lead", 10'(up.lead), 10'h000);
    check("div_en", {8'h00, up.div_en, lo.div_en}, 10'h003);
    for (int a = 0; a < 8; a++)
    begin
      i_ogdpc_host.read_byte(3'(a), rd);
      check("reset_byte", 10'(rd), 10'(rst_b[a]));
    end
    for (int i = 0; i < 12; i++)
    begin
      wr_settle(t_a[i], t_d[i]);
      check("out_enable", out_enable, t_o[i]);
      check("div_en", {8'h00, up.div_en, lo.div_en}, 10'(t_v[i]));
      check("chip_enable", 10'(chip_enable), (t_a[i] == 3'h5) ? 10'(t_d[i][7]) : 10'h001);
      i_ogdpc_host.read_byte(t_a[i], rd);
      check("readback", 10'(rd), 10'(t_r[i]));
    end
    // Only the eleven defined ratio codes are written.
    for (int c = 0; c < 11; c++)
    begin
      for (int p = 0; p < 4; p++)
      begin
        i_ogdpc_host.write_byte(OFF_RATIO_UP, 8'h30 | 8'(c));
        i_ogdpc_host.write_byte(OFF_RATIO_LO, 8'h30 | 8'(c));
        i_ogdpc_host.write_byte(OFF_PHASE_LO, {3'h0, phs[p]});
        wr_settle(OFF_PHASE_UP, {3'h1, phs[p]});
        check("upper_ratio", 10'(up.ratio), 10'(ratio_of[c]));
        check("lower_ratio", 10'(lo.ratio), 10'(ratio_of[c]));
        check("upper_lead", 10'(up.lead), exp_val(c, p, 1'b0));
        check("upper_steps", 10'(up.steps), exp_val(c, p, 1'b1));
        check("lower_steps", 10'(lo.steps), exp_val(c, p, 1'b1));
        check("lower_lead", 10'(lo.lead), 10'h000);
      end
    end
    // With the phase enable clear the upper group gets no lead at divide by 80.
    wr_settle(OFF_PHASE_UP, 8'h1F);
    check("upper_lead", 10'(up.lead), 10'h000);
    check("upper_ratio", 10'(up.ratio), 10'd80);
    complete_run();
  end
endmodule // tb
`default_nettype wire
